// ### rtc_top.sv
// range, autorange, trip and power-on control for four voltmeter channels
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module rtc_top
	import rtc_pkg::*;
#(
	parameter longint LONG_CYC  = rtc_pkg::LONG_PRESS_CYC,
	parameter longint TEST_CYC  = rtc_pkg::SELFTEST_CYC,
	parameter longint LAMPS_CYC = rtc_pkg::LAMP_CYC
)
(
	input  wire logic                    SYS_CLK,
	input  wire logic                    RESET_N,
	input  wire logic                    CLK_EN,
	input  wire logic [rtc_pkg::NUM_CH-1:0] BUTTON_N,
	input  wire logic [rtc_pkg::NUM_CH-1:0] ATTEN_ON,
	input  wire logic [4*rtc_pkg::MAG_W-1:0] IN_MAG_MV,
	input  wire logic [4*rtc_pkg::RD_W-1:0] ADC_DATA,
	input  wire logic                    ADC_VALID,
	input  wire logic                    EXT_TRIG_N,
	input  wire logic                    LINE50_NV,
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [7:0]              PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic [31:0]                  PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	output logic [rtc_pkg::NUM_CH-1:0]   AUTO_LED,
	output logic [4*rtc_pkg::NUM_CH-1:0] RANGE_LED,
	output logic [rtc_pkg::NUM_CH-1:0]   TRIP_MSG,
	output logic [rtc_pkg::NUM_CH-1:0]   PROTECT_OPEN,
	output logic                         TEST_MSG,
	output logic                         LINE50,
	output logic [1:0]                   CAL_SEL,
	output logic                         CONV_START
);
	import rtc_pkg::*;

	typedef struct packed {
		rtc_phase_t             phase;
		logic [CNT_W-1:0]       tcnt;
		logic [3:0][2:0]        s_btn;
		logic [3:0][2:0]        s_ext;
		logic                   ext_lvl;
		logic [3:0][CNT_W-1:0]  hold;
		logic [3:0]             long_done;
		logic [3:0]             autor;
		logic [3:0][1:0]        rng;
		logic [3:0]             remote;
		logic [3:0]             trip;
		logic [3:0]             auto_try;
		logic                   ext_sel;
		logic                   line50;
		rtc_cal_t               cal;
		logic                   busy;
		logic [3:0][RD_W-1:0]   rd;
		logic [2:0]             mode_reg;
		logic                   line_loaded;
		logic [31:0]            prdata;
	} rtc_state_t;

	rtc_state_t r;
	rtc_state_t n;

	logic       acc;
	logic       wr;
	logic       ext_fall;
	logic [3:0] over;

	function automatic logic [1:0] auto_pick(input logic [MAG_W-1:0] m);
		if (m <= R4_MAX_MV)
			auto_pick = 2'h3;
		else if (m <= R3_MAX_MV)
			auto_pick = 2'h2;
		else if (m <= R2_MAX_MV)
			auto_pick = 2'h1;
		else
			auto_pick = 2'h0;
	endfunction

	assign acc = PSEL & PENABLE;
	assign wr = acc & PWRITE;
	// active low: counts once the second and third stages agree low after a settled high
	assign ext_fall = r.ext_lvl & ~r.s_ext[0][2] & ~r.s_ext[0][1];

	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			over[c] = ATTEN_ON[c] ? (IN_MAG_MV[c*MAG_W +: MAG_W] > TRIP_ATT_MV)
				: (IN_MAG_MV[c*MAG_W +: MAG_W] > TRIP_DIR_MV);
		end
	end

	always_comb
	begin
		logic       pressed;
		logic       released;
		logic       clr_req;
		logic       trig;
		n = r;
		pressed = 1'b0;
		released = 1'b0;
		clr_req = 1'b0;
		trig = 1'b0;
		n.s_ext[0] = {r.s_ext[0][1:0], EXT_TRIG_N};
		// settled level only moves when the two older stages agree
		if (r.s_ext[0][2] == r.s_ext[0][1])
			n.ext_lvl = r.s_ext[0][2];
		if (!r.line_loaded)
		begin
			n.line50 = LINE50_NV;
			n.line_loaded = 1'b1;
		end
		case (r.phase)
			RTC_ST_TEST:
			begin
				n.tcnt = r.tcnt + 1'b1;
				if (r.tcnt >= CNT_W'(TEST_CYC - 1))
				begin
					n.phase = RTC_ST_LAMP;
					n.tcnt = '0;
				end
			end
			RTC_ST_LAMP:
			begin
				n.tcnt = r.tcnt + 1'b1;
				if (r.tcnt >= CNT_W'(LAMPS_CYC - 1))
				begin
					n.phase = RTC_ST_RUN;
					n.tcnt = '0;
				end
			end
			default:
			begin
				n.phase = RTC_ST_RUN;
			end
		endcase
		// trigger: local free-run, external, or host request, all channels together
		if (r.phase == RTC_ST_RUN && !r.busy)
		begin
			if (wr && PADDR == A_CTRL && PWDATA[B_TRIG])
				trig = 1'b1;
			else if (r.ext_sel)
				trig = ext_fall;
			else
				trig = 1'b1;
		end
		if (trig)
		begin
			n.busy = 1'b1;
			n.cal = RTC_CAL_IN;
		end
		else if (r.busy && ADC_VALID)
		begin
			case (r.cal)
				RTC_CAL_IN:  n.cal = RTC_CAL_GND;
				RTC_CAL_GND: n.cal = RTC_CAL_MID;
				default:
				begin
					n.busy = 1'b0;
					for (int c = 0; c < NUM_CH; c++)
						if (!r.trip[c])
							n.rd[c] = ADC_DATA[c*RD_W +: RD_W];
				end
			endcase
		end
		for (int c = 0; c < NUM_CH; c++)
		begin
			n.s_btn[c] = {r.s_btn[c][1:0], ~BUTTON_N[c]};
			pressed = r.s_btn[c][2] & r.s_btn[c][1];
			released = ~r.s_btn[c][2] & ~r.s_btn[c][1];
			clr_req = wr && PADDR == A_CTRL && PWDATA[B_CLR_TRIP + c];
			if (r.phase != RTC_ST_RUN)
			begin
				n.hold[c] = '0;
			end
			else if (pressed)
			begin
				if (r.hold[c] != '1)
					n.hold[c] = r.hold[c] + 1'b1;
				// long press acts once while held; identical for any trigger source
				if (r.hold[c] == CNT_W'(LONG_CYC) && !r.trip[c] && !r.long_done[c])
				begin
					n.autor[c] = ~r.autor[c];
					n.long_done[c] = 1'b1;
					n.remote[c] = 1'b0;
				end
			end
			else if (released)
			begin
				if (r.hold[c] != '0 && r.hold[c] <= CNT_W'(LONG_CYC) && !r.long_done[c])
				begin
					if (r.trip[c])
						clr_req = 1'b1;
					else if (r.remote[c])
					begin
						n.rng[c] = rtc_nearest(r.mode_reg);
						n.remote[c] = 1'b0;
					end
					else if (!r.autor[c])
						n.rng[c] = r.rng[c] + 2'h1;
				end
				n.hold[c] = '0;
				n.long_done[c] = 1'b0;
			end
			if (r.autor[c] && !r.remote[c] && !r.trip[c])
				n.rng[c] = auto_pick(IN_MAG_MV[c*MAG_W +: MAG_W]);
			if (wr && PADDR == A_CTRL && PWDATA[B_MODE_SET + c])
			begin
				n.remote[c] = 1'b1;
				n.autor[c] = 1'b0;
				n.rng[c] = rtc_nearest(PWDATA[18:16]);
			end
			// trip set wins over any clear in the same cycle
			if (over[c])
			begin
				if (!r.trip[c])
					n.auto_try[c] = 1'b0;
				n.trip[c] = 1'b1;
			end
			else if (r.trip[c] && (clr_req || !r.auto_try[c]))
			begin
				n.trip[c] = 1'b0;
			end
			if (r.trip[c] && !r.auto_try[c])
				n.auto_try[c] = 1'b1;
		end
		if (wr && PADDR == A_CTRL)
		begin
			n.ext_sel = PWDATA[B_EXT_SEL];
			n.line50 = PWDATA[B_LINE50];
		end
		if (wr && PADDR == A_MODE)
			n.mode_reg = PWDATA[2:0];
		// read data is latched in the setup cycle so it stands from a flop in the access phase
		if (PSEL && !PENABLE && !PWRITE)
		begin
			if (PADDR == A_CTRL)
				n.prdata = {24'h000000, r.line50, r.ext_sel, 6'h00};
			else if (PADDR == A_STATUS)
				n.prdata = {20'h00000, r.remote, r.trip, r.autor};
			else if (PADDR == A_RANGE)
				n.prdata = {24'h000000, r.rng[3], r.rng[2], r.rng[1], r.rng[0]};
			else if (PADDR == A_MODE)
				n.prdata = {29'h00000000, r.mode_reg};
			else if (PADDR >= A_READ0 && PADDR < A_ID && PADDR[1:0] == 2'h0)
				n.prdata = {8'h00, r.rd[PADDR[3:2]]};
			else if (PADDR == A_ID)
				n.prdata = ID_CODE;
			else
				n.prdata = 32'h00000000;
		end
		if (wr && PADDR == A_CTRL && PWDATA[B_RESET_CFG])
		begin
			// host reset: power-on settings without the self-test, straight to run; line frequency kept
			n.phase = RTC_ST_RUN;
			n.autor = '1;
			n.rng = '0;
			n.remote = '0;
			n.ext_sel = 1'b0;
			n.line50 = r.line50;
			n.mode_reg = '0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			r <= '0;
			r.phase <= RTC_ST_TEST;
			r.autor <= '1;
			r.s_btn <= '0;
			r.s_ext <= '1;
			r.ext_lvl <= 1'b1;
			r.cal <= RTC_CAL_IN;
		end
		else if (CLK_EN)
		begin
			r <= n;
		end
	end

	// access phase answers in its first cycle; read data captured on setup is shown
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = r.prdata;

	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			AUTO_LED[c] = (r.phase == RTC_ST_LAMP) | (r.phase == RTC_ST_RUN & r.autor[c]);
			RANGE_LED[c*4 +: 4] = (r.phase == RTC_ST_LAMP) ? 4'hF
				: (r.phase == RTC_ST_RUN ? 4'(4'h1 << r.rng[c]) : 4'h0);
		end
	end
	assign TRIP_MSG = r.trip;
	assign PROTECT_OPEN = r.trip;
	assign TEST_MSG = (r.phase == RTC_ST_TEST);
	assign LINE50 = r.line50;
	assign CAL_SEL = r.cal;
	assign CONV_START = r.busy;
endmodule

// ### rtc_pkg.sv
// constants and types shared by the range and trip control block
package rtc_pkg;
	localparam int          CLK_HZ         = 125000000;
	localparam int          NUM_CH         = 4;
	localparam int          LONG_PRESS_MS  = 1500;
	localparam longint      LONG_PRESS_CYC = (longint'(LONG_PRESS_MS) * CLK_HZ) / 1000;
	localparam int          SELFTEST_MS    = 1000;
	localparam int          LAMP_MS        = 500;
	localparam longint      SELFTEST_CYC   = (longint'(SELFTEST_MS) * CLK_HZ) / 1000;
	localparam longint      LAMP_CYC       = (longint'(LAMP_MS) * CLK_HZ) / 1000;
	localparam int          CNT_W          = 32;
	localparam int          RD_W           = 24;
	// magnitudes in millivolts
	localparam int          MAG_W          = 16;
	localparam logic [15:0] TRIP_ATT_MV    = 16'h7530;
	localparam logic [15:0] TRIP_DIR_MV    = 16'h0BB8;
	// autorange thresholds in millivolts, largest range first
	localparam logic [15:0] R2_MAX_MV      = 16'h07CF;
	localparam logic [15:0] R3_MAX_MV      = 16'h03E7;
	localparam logic [15:0] R4_MAX_MV      = 16'h00C7;
	localparam logic [31:0] ID_CODE        = 32'h00000000; // arbitrary value

	// APB register map (byte addresses)
	localparam logic [7:0]  A_CTRL   = 8'h00;
	localparam logic [7:0]  A_STATUS = 8'h04;
	localparam logic [7:0]  A_RANGE  = 8'h08;
	localparam logic [7:0]  A_MODE   = 8'h0C;
	localparam logic [7:0]  A_READ0  = 8'h10;
	localparam logic [7:0]  A_ID     = 8'h20;
	// CTRL bits (write-one pulses and levels)
	localparam int B_CLR_TRIP  = 0;  // [3:0] per channel
	localparam int B_RESET_CFG = 4;
	localparam int B_TRIG      = 5;
	localparam int B_EXT_SEL   = 6;
	localparam int B_LINE50    = 7;
	localparam int B_MODE_SET  = 8;  // [11:8] per channel, load range from PWDATA[18:16]

	typedef enum logic [1:0] {RTC_ST_TEST, RTC_ST_LAMP, RTC_ST_RUN} rtc_phase_t;
	typedef enum logic [1:0] {RTC_CAL_IN, RTC_CAL_GND, RTC_CAL_MID} rtc_cal_t;

	// nearest front-panel range for a remote mode code 0..7 (codes 0..3 are ranges 1..4)
	function automatic logic [1:0] rtc_nearest(input logic [2:0] mode);
		rtc_nearest = (mode[2]) ? 2'(mode[1:0] ^ 2'h0) : mode[1:0];
	endfunction
endpackage

// ### rtc_asserts.sv
// port-level assertions for the range and trip control block
`timescale 1ns/10ps
module rtc_chk
	import rtc_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        RESET_N,
	input wire logic [3:0]  ATTEN_ON,
	input wire logic [63:0] IN_MAG_MV,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [3:0]  AUTO_LED,
	input wire logic [15:0] RANGE_LED,
	input wire logic [3:0]  TRIP_MSG,
	input wire logic [3:0]  PROTECT_OPEN,
	input wire logic        TEST_MSG,
	input wire logic        CONV_START
);
	logic [15:0] mag3;
	assign mag3 = IN_MAG_MV[63:48];
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_over_dir;
		!TEST_MSG && !ATTEN_ON[3] && mag3 > TRIP_DIR_MV;
	endsequence
	sequence s_over_att;
		!TEST_MSG && mag3 > TRIP_ATT_MV;
	endsequence
	a_ready_high: assert property (PREADY)
		else $error("pready low");
	a_no_slverr: assert property (!PSLVERR)
		else $error("pslverr set");
	a_trip_dir: assert property (s_over_dir |-> ##[0:4] PROTECT_OPEN[3])
		else $error("no trip on direct overload");
	a_trip_att: assert property (s_over_att |-> ##[0:4] PROTECT_OPEN[3])
		else $error("no trip on attenuated overload");
	a_trip_hold: assert property (PROTECT_OPEN[3] && mag3 > TRIP_ATT_MV |=> PROTECT_OPEN[3])
		else $error("trip released under overload");
	a_trip_msg: assert property (TRIP_MSG == PROTECT_OPEN)
		else $error("trip message differs from protection");
	a_test_quiet: assert property (TEST_MSG |-> !CONV_START)
		else $error("conversion during self-test");
	a_lamps_on: assert property ($fell(TEST_MSG) |-> AUTO_LED == 4'hF && RANGE_LED == 16'hFFFF)
		else $error("lamps not all lit after test");
endmodule

// ### rtc_adc_model.sv
// converter stand-in: first reading four cycles into converting, then one per sixteen cycles
`timescale 1ns/10ps
module rtc_adc_model
(
	input wire logic    clk,
	input wire logic    rst_n,
	input wire logic    conv_start,
	output logic [95:0] adc_data,
	output logic        adc_valid
);
	logic [3:0]  cnt;
	logic [23:0] seq;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cnt <= 4'h0;
			seq <= 24'h000100;
			adc_valid <= 1'b0;
			adc_data <= 96'h0;
		end
		else
		begin
			cnt <= conv_start ? cnt + 4'h1 : 4'h0;
			adc_valid <= conv_start && cnt == 4'h3;
			seq <= (conv_start && cnt == 4'h3) ? seq + 24'h000101 : seq;
			// data churns between readings so a stale sample is never mistaken for one
			adc_data <= (conv_start && cnt == 4'h3) ? {4{seq}} : ~adc_data;
		end
endmodule

// ### rtc_top_bench.sv
// self-checking bench for the range and trip control block
`timescale 1ns/10ps
module rtc_top_bench;
	import rtc_pkg::*;
	logic        SYS_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic        EXT_TRIG_N = 1;
	logic [3:0]  BUTTON_N = 4'hF, ATTEN_ON = 4'hF;
	logic [63:0] IN_MAG_MV = {4{16'h2710}};
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd, r0;
	logic        PREADY, PSLVERR, TEST_MSG, LINE50, CONV_START, ADC_VALID;
	logic [3:0]  AUTO_LED, TRIP_MSG, PROTECT_OPEN;
	logic [15:0] RANGE_LED;
	logic [1:0]  CAL_SEL;
	logic [95:0] ADC_DATA;
	int          failures = 0, n_checks = 0;
	always #4 SYS_CLK = ~SYS_CLK;
	rtc_top #(.LONG_CYC(20), .TEST_CYC(10), .LAMPS_CYC(10)) u_dut (.SYS_CLK(SYS_CLK),
		.RESET_N(RESET_N), .CLK_EN(1'b1), .BUTTON_N(BUTTON_N), .ATTEN_ON(ATTEN_ON),
		.IN_MAG_MV(IN_MAG_MV), .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID),
		.EXT_TRIG_N(EXT_TRIG_N),
		.LINE50_NV(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.AUTO_LED(AUTO_LED), .RANGE_LED(RANGE_LED), .TRIP_MSG(TRIP_MSG),
		.PROTECT_OPEN(PROTECT_OPEN), .TEST_MSG(TEST_MSG), .LINE50(LINE50),
		.CAL_SEL(CAL_SEL), .CONV_START(CONV_START));
	rtc_adc_model u_adc (.clk(SYS_CLK), .rst_n(RESET_N), .conv_start(CONV_START),
		.adc_data(ADC_DATA), .adc_valid(ADC_VALID));
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		tick(1);
		PENABLE <= 1;
		do tick(1); while (PREADY !== 1'b1);
		rd = PRDATA;
		PSEL <= 0;
		PENABLE <= 0;
		tick(1);
	endtask
	// buttons pass a three-stage synchroniser, so allow settling after release
	task press(input int ch, input int n);
		BUTTON_N[ch] <= 0;
		tick(n);
		BUTTON_N[ch] <= 1;
		tick(10);
	endtask
	task run_up;
		for (int i = 0; i < 200 && TEST_MSG !== 1'b0; i++)
			tick(1);
		tick(15);
	endtask
	task t_power;
		chk(TEST_MSG, 1);
		run_up;
		chk(AUTO_LED, 4'hF);
		chk(RANGE_LED, 16'h1111);
		chk(LINE50, 1);
		apb(0, 8'h08, 0);
		chk(rd, 0);
		apb(1, 8'h44, 32'hFFFFFFFF);
		apb(0, 8'h44, 0);
		chk(rd, 0);
		chk(AUTO_LED, 4'hF);
	endtask
	task t_buttons;
		logic [3:0] e;
		e = 4'h1;
		press(1, 3);
		chk(RANGE_LED[7:4], 4'h1);
		press(0, 30);
		chk(AUTO_LED[1:0], 2'h2);
		for (int i = 0; i < 4; i++)
		begin
			e = {e[2:0], e[3]};
			press(0, 3);
			chk(RANGE_LED[3:0], e);
		end
		apb(0, 8'h08, 0);
		chk(rd[1:0], 0);
		press(0, 30);
		chk(AUTO_LED[0], 1);
	endtask
	task t_auto;
		IN_MAG_MV[47:32] <= 16'h0064;
		tick(60);
		chk(RANGE_LED[11:8], 4'h8);
	endtask
	task t_trip;
		press(3, 30);
		chk(AUTO_LED[3], 0);
		ATTEN_ON[3] <= 0;
		IN_MAG_MV[63:48] <= 16'h0FA0;
		tick(10);
		chk(PROTECT_OPEN[3], 1);
		press(3, 3);
		chk(PROTECT_OPEN[3], 1);
		chk(RANGE_LED[15:12], 4'h1);
		IN_MAG_MV[63:48] <= 16'h0064;
		apb(0, 8'h1C, 0);
		r0 = rd;
		chk(rd[31:24], 0);
		tick(100);
		chk(PROTECT_OPEN[3], 1);
		apb(0, 8'h1C, 0);
		chk(rd, r0);
		press(3, 3);
		chk(PROTECT_OPEN[3], 0);
		chk(AUTO_LED[3], 0);
		chk(RANGE_LED[15:12], 4'h1);
		ATTEN_ON[3] <= 1;
		IN_MAG_MV[63:48] <= 16'h7600;
		tick(10);
		chk(TRIP_MSG[3], 1);
		IN_MAG_MV[63:48] <= 16'h0064;
		tick(10);
		apb(1, 8'h00, 32'h8);
		tick(5);
		chk(PROTECT_OPEN[3], 0);
	endtask
	// external trigger selected: no free run, host and pin triggers start the cal sequence
	task t_ext;
		apb(1, 8'h00, 32'h40);
		tick(60);
		chk(CONV_START, 0);
		apb(1, 8'h00, 32'h60);
		chk(CONV_START, 1);
		chk(CAL_SEL, 0);
		tick(8);
		chk(CAL_SEL, 1);
		tick(20);
		chk(CAL_SEL, 2);
		tick(30);
		EXT_TRIG_N <= 0;
		tick(6);
		chk(CONV_START, 1);
		EXT_TRIG_N <= 1;
		press(1, 30);
		chk(AUTO_LED[1], 0);
		press(1, 3);
		chk(RANGE_LED[7:4], 4'h2);
	endtask
	task t_restore;
		press(0, 30);
		apb(1, 8'h00, 32'h10);
		run_up;
		chk(AUTO_LED, 4'hF);
		chk(RANGE_LED[3:0], 4'h1);
	endtask
	initial
	begin
		tick(8);
		RESET_N <= 1;
		t_power;
		t_buttons;
		t_auto;
		t_trip;
		t_ext;
		t_restore;
		tally_and_finish;
	end
	initial
	begin
		tick(20000);
		failures++;
		tally_and_finish;
	end
endmodule
bind rtc_top rtc_chk u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .ATTEN_ON(ATTEN_ON),
	.IN_MAG_MV(IN_MAG_MV), .PREADY(PREADY), .PSLVERR(PSLVERR), .AUTO_LED(AUTO_LED),
	.RANGE_LED(RANGE_LED), .TRIP_MSG(TRIP_MSG), .PROTECT_OPEN(PROTECT_OPEN),
	.TEST_MSG(TEST_MSG), .CONV_START(CONV_START));
